// >>> core/idx_op_decode.sv
// Decode and execute of indexed add, bit-set and fill operations with an
// APB register front end and a port to an external byte data memory.
// Assumes the memory returns mem_rdata in the cycle its address is held.
`include "idx_op_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module idx_op_decode
  import idx_op_pkg::*;
#(
  parameter int          DATA_AW         = 12,
  parameter logic [11:0] ACCESS_SFR_BASE = 12'hF00
) (
  input  wire logic        mclk,
  input  wire logic        rstn,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  output var  mem_req_t    mem_req,
  input  wire logic [7:0]  mem_rdata
);

  // Effective address of an operand byte
  function automatic logic [11:0] eff_addr(
    input logic [7:0]  f,
    input logic        acc,
    input logic        ext,
    input logic [11:0] fp,
    input logic [3:0]  bank
  );
    logic [11:0] res;
    res = `ZERO12;
    if (ext && !acc && (f <= `ACC_BOUND)) begin
      res = fp + {4'h0, f};
    end else if (!acc) begin
      if (f <= `ACC_BOUND) begin
        res = {4'h0, f};
      end else begin
        res = ACCESS_SFR_BASE | {4'h0, f};
      end
    end else begin
      res = {bank, f};
    end
    return res;
  endfunction

  // Byte add with all five flags
  function automatic logic [12:0] add_flags(
    input logic [7:0] a,
    input logic [7:0] b
  );
    logic [8:0]  sum;
    logic [4:0]  low;
    alu_flags_t  fl;
    sum = {1'b0, a} + {1'b0, b};
    low = {1'b0, a[3:0]} + {1'b0, b[3:0]};
    fl.c  = sum[8];
    fl.dc = low[4];
    fl.z  = (sum[7:0] == `ZERO8);
    fl.n  = sum[7];
    fl.ov = (a[7] == b[7]) && (sum[7] != a[7]);
    return {fl, sum[7:0]};
  endfunction

  // Registers
  logic             ext_en_r;
  logic [15:0]      opcode_r;
  logic [11:0]      frame_ptr_r;
  logic [3:0]       bank_sel_r;
  logic [7:0]       accum_r;
  alu_flags_t       flags_r;
  logic             bad_r;
  logic [11:0]      last_addr_r;
  exec_state_t      state_r;
  exec_state_t      state_nxt;
  logic [31:0]      prdata_r;
  logic             pslverr_r;
  mem_req_t         mem_req_r;
  logic [7:0]       accum_nxt;
  alu_flags_t       flags_nxt;
  mem_req_t         mem_req_nxt;

  // Bus decode
  wire logic        busy      = (state_r != ST_IDLE);
  wire logic        setup     = psel && !penable;
  wire logic        access    = psel && penable;
  wire logic        hit_ctrl  = (paddr == `REG_CTRL);
  wire logic        hit_op    = (paddr == `REG_OPCODE);
  wire logic        hit_fp    = (paddr == `REG_FRAME_PTR);
  wire logic        hit_bank  = (paddr == `REG_BANK_SEL);
  wire logic        hit_acc   = (paddr == `REG_ACCUM);
  wire logic        hit_stat  = (paddr == `REG_STATUS);
  wire logic        hit_last  = (paddr == `REG_LAST_ADDR);
  wire logic        mapped    = hit_ctrl || hit_op || hit_fp || hit_bank ||
                                hit_acc || hit_stat || hit_last;
  // Writes are refused while an operation runs, so state never tears
  wire logic        wr_refuse = pwrite && (busy || hit_last);
  wire logic        err_now   = !mapped || wr_refuse;
  wire logic        wr_ok     = access && pwrite && !pslverr_r;
  wire logic        launch    = wr_ok && hit_op;

  // Operation fields
  wire logic [7:0]  op_f      = opcode_r[7:0];
  wire logic        op_acc    = opcode_r[`OP_ACC_BIT];
  wire logic        op_dest   = opcode_r[`OP_DEST_BIT];
  wire logic [2:0]  op_bit    = opcode_r[`OP_BIT_HI:`OP_BIT_LO];
  wire logic        is_add    = ((opcode_r & `OPM_ADD) == `OPV_ADD);
  wire logic        is_bset   = ((opcode_r & `OPM_BSET) == `OPV_BSET);
  wire logic        is_fill   = ((opcode_r & `OPM_FILL) == `OPV_FILL);
  wire op_class_t   op_class  = is_add  ? OPC_ADD  :
                                is_bset ? OPC_BSET :
                                is_fill ? OPC_FILL : OPC_NONE;
  // One configuration bit turns on both the extension and indexing
  wire logic        ext_mode  = ext_en_r;
  wire logic [11:0] op_addr   = eff_addr(op_f, op_acc, ext_mode,
                                         frame_ptr_r, bank_sel_r);
  wire logic [12:0] add_res   = add_flags(accum_r, mem_rdata);
  wire logic [7:0]  bit_mask  = `ONE8 << op_bit;

  // Read mux, sampled in the setup cycle
  wire logic [31:0] rd_mux =
    hit_ctrl ? {31'h0000_0000, ext_en_r} :
    hit_op   ? {16'h0000, opcode_r} :
    hit_fp   ? {20'h0_0000, frame_ptr_r} :
    hit_bank ? {28'h000_0000, bank_sel_r} :
    hit_acc  ? {24'h00_0000, accum_r} :
    hit_stat ? {22'h00_0000, bad_r, busy, 3'h0, flags_r} :
    hit_last ? {20'h0_0000, last_addr_r} : `ZERO32;

  // Execution sequence: decode, read operand (skipped by fill), write back
  always_comb begin
    state_nxt   = state_r;
    accum_nxt   = accum_r;
    flags_nxt   = flags_r;
    mem_req_nxt = '0;
    unique case (state_r)
      ST_IDLE: begin
        if (launch) begin
          state_nxt = ST_DEC;
        end
      end
      ST_DEC: begin
        if (op_class == OPC_NONE) begin
          state_nxt = ST_IDLE;
        end else if (op_class == OPC_FILL) begin
          mem_req_nxt.addr  = op_addr;
          mem_req_nxt.wdata = `FILL_BYTE;
          mem_req_nxt.we    = 1'b1;
          state_nxt         = ST_WB;
        end else begin
          mem_req_nxt.addr = op_addr;
          mem_req_nxt.re   = 1'b1;
          state_nxt        = ST_RD;
        end
      end
      ST_RD: begin
        mem_req_nxt.addr = mem_req_r.addr;
        state_nxt        = ST_WB;
        if (op_class == OPC_ADD) begin
          flags_nxt = alu_flags_t'(add_res[12:8]);
          if (op_dest) begin
            mem_req_nxt.wdata = add_res[7:0];
            mem_req_nxt.we    = 1'b1;
          end else begin
            accum_nxt = add_res[7:0];
          end
        end else begin
          mem_req_nxt.wdata = mem_rdata | bit_mask;
          mem_req_nxt.we    = 1'b1;
        end
      end
      ST_WB: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // Sequence and memory request registers
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state_r   <= ST_IDLE;
      mem_req_r <= '0;
    end else begin
      state_r   <= state_nxt;
      mem_req_r <= mem_req_nxt;
    end
  end

  // Accumulator and flags; a bus write only lands while idle
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      accum_r <= `ZERO8;
      flags_r <= '0;
    end else if (wr_ok && hit_acc) begin
      accum_r <= pwdata[7:0];
    end else if (wr_ok && hit_stat) begin
      flags_r <= alu_flags_t'(pwdata[4:0]);
    end else begin
      accum_r <= accum_nxt;
      flags_r <= flags_nxt;
    end
  end

  // Configuration, pointer and bank registers
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ext_en_r    <= `CTRL_RST;
      frame_ptr_r <= `ZERO12;
      bank_sel_r  <= 4'h0;
      opcode_r    <= `ZERO16;
    end else begin
      if (wr_ok && hit_ctrl) begin
        ext_en_r <= pwdata[0];
      end
      if (wr_ok && hit_fp) begin
        frame_ptr_r <= pwdata[11:0];
      end
      if (wr_ok && hit_bank) begin
        bank_sel_r <= pwdata[3:0];
      end
      if (launch) begin
        opcode_r <= pwdata[15:0];
      end
    end
  end

  // Unknown opcode flag: the set wins over a software clear
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      bad_r <= 1'b0;
    end else if (state_r == ST_DEC && op_class == OPC_NONE) begin
      bad_r <= 1'b1;
    end else if (wr_ok && hit_stat && pwdata[`ST_BAD]) begin
      bad_r <= 1'b0;
    end
  end

  // Address of the most recent memory access, for software to inspect
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      last_addr_r <= `ZERO12;
    end else if (state_r == ST_DEC && op_class != OPC_NONE) begin
      last_addr_r <= op_addr;
    end
  end

  // Read data and error are captured in setup, so access never waits
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      prdata_r  <= `ZERO32;
      pslverr_r <= 1'b0;
    end else if (setup) begin
      prdata_r  <= pwrite ? `ZERO32 : rd_mux;
      pslverr_r <= err_now;
    end
  end

  assign prdata  = prdata_r;
  assign pready  = 1'b1;
  assign pslverr = access && pslverr_r;
  assign mem_req = mem_req_r;

endmodule // idx_op_decode

`default_nettype wire

// >>> inc/idx_op_cfg.svh
// Constants for the indexed-offset operation decoder: register map,
// field positions, opcode patterns and reset values.
// Assumes inclusion by bare name from the core; the package does not include it.
`ifndef IDX_OP_CFG_SVH
`define IDX_OP_CFG_SVH

// Register byte offsets on the bus
`define REG_CTRL       8'h00
`define REG_OPCODE     8'h04
`define REG_FRAME_PTR  8'h08
`define REG_BANK_SEL   8'h0C
`define REG_ACCUM      8'h10
`define REG_STATUS     8'h14
`define REG_LAST_ADDR  8'h18

// Reset values
`define CTRL_RST       1'b1
`define ZERO8          8'h00
`define ZERO12         12'h000
`define ZERO16         16'h0000
`define ZERO32         32'h0000_0000

// Status register field positions
`define ST_C           0
`define ST_DC          1
`define ST_Z           2
`define ST_OV          3
`define ST_N           4
`define ST_BUSY        8
`define ST_BAD         9

// Opcode patterns and masks
`define OPM_ADD        16'hFC00
`define OPV_ADD        16'h2400
`define OPM_BSET       16'hF000
`define OPV_BSET       16'h8000
`define OPM_FILL       16'hFE00
`define OPV_FILL       16'h6800
`define OP_DEST_BIT    9
`define OP_ACC_BIT     8
`define OP_BIT_HI      11
`define OP_BIT_LO      9

// Access boundary and fill value
`define ACC_BOUND      8'h5F
`define FILL_BYTE      8'hFF
`define ONE8           8'h01

`endif

// >>> inc/idx_op_pkg.sv
// Types shared by the indexed-offset operation decoder.
// Assumes the constants header sits on the include path.
package idx_op_pkg;

  // Execution sequence of one operation
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_DEC  = 2'b01,
    ST_RD   = 2'b10,
    ST_WB   = 2'b11
  } exec_state_t;

  // Request toward the external data memory
  typedef struct packed {
    logic [11:0] addr;
    logic [7:0]  wdata;
    logic        we;
    logic        re;
  } mem_req_t;

  // Arithmetic status flags
  typedef struct packed {
    logic n;
    logic ov;
    logic z;
    logic dc;
    logic c;
  } alu_flags_t;

  // Operation class after decode
  typedef enum logic [1:0] {
    OPC_NONE = 2'b00,
    OPC_ADD  = 2'b01,
    OPC_BSET = 2'b10,
    OPC_FILL = 2'b11
  } op_class_t;

endpackage

// >>> bench/idx_op_decode_monitor.sv
// Checker for the indexed operation decoder, bound onto its top ports.
// Assumes APB stimulus and a byte memory answering on mem_rdata.
`timescale 1ns/1ps
`default_nettype none
module idx_op_decode_monitor
  import idx_op_pkg::*;
#(
  parameter logic [11:0] ACCESS_SFR_BASE = 12'hF00
) (
  input wire logic        mclk,
  input wire logic        rstn,
  input wire logic [7:0]  paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire mem_req_t    mem_req,
  input wire logic [7:0]  mem_rdata
);
  logic        wr_ok;
  logic        op_go;
  logic        is_add;
  logic        is_bset;
  logic        is_fill;
  logic        op_ok;
  logic [11:0] fp_r;
  logic        ext_r;
  logic [7:0]  k_r;
  // Accepted writes only; a refused one must not move the shadows
  assign wr_ok   = psel && penable && pwrite && pready && !pslverr;
  assign op_go   = wr_ok && paddr == 8'h04;
  assign is_add  = (pwdata[15:0] & 16'hFC00) == 16'h2400;
  assign is_bset = (pwdata[15:0] & 16'hF000) == 16'h8000;
  assign is_fill = (pwdata[15:0] & 16'hFE00) == 16'h6800;
  assign op_ok   = op_go && (is_add || is_bset || is_fill);
  // Shadows of pointer, mode and offset, as the registers are out of sight
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      fp_r  <= 12'h000;
      ext_r <= 1'b1;
      k_r   <= 8'h00;
    end else begin
      fp_r  <= (wr_ok && paddr == 8'h08) ? pwdata[11:0] : fp_r;
      ext_r <= (wr_ok && paddr == 8'h00) ? pwdata[0] : ext_r;
      k_r   <= op_go ? pwdata[7:0] : k_r;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  // Read step of a read-modify-write operation
  sequence s_read;
    mem_req.re && !mem_req.we;
  endsequence
  property p_add_dest;
    op_go && is_add |-> ##2 s_read ##1 mem_req.we == $past(pwdata[9], 3);
  endproperty
  property p_bset;
    op_go && is_bset |-> ##2 s_read ##1 mem_req.we && mem_req.wdata ==
      ($past(mem_rdata) | (8'h01 << $past(pwdata[11:9], 3)));
  endproperty
  property p_fill;
    op_go && is_fill |-> ##2 mem_req.we && !mem_req.re
      && mem_req.wdata == 8'hFF;
  endproperty
  property p_index;
    op_ok && ext_r && !pwdata[8] && pwdata[7:0] <= 8'h5F
      |-> ##2 mem_req.addr == fp_r + {4'h0, k_r};
  endproperty
  property p_literal;
    op_ok && !pwdata[8] && (!ext_r || pwdata[7:0] > 8'h5F) |-> ##2
      mem_req.addr == (k_r > 8'h5F ? ACCESS_SFR_BASE | {4'h0, k_r}
                                   : {4'h0, k_r});
  endproperty
  property p_bad;
    op_go && !op_ok |-> ##1 (!mem_req.re && !mem_req.we) [*3];
  endproperty
  property p_ro_refused;
    psel && penable && pwrite && paddr == 8'h18 |-> pslverr;
  endproperty
  property p_ready;
    psel && penable |-> pready;
  endproperty
  // A read or write step on the memory port means an operation is running
  property p_busy_refused;
    psel && !penable && pwrite && (mem_req.re || mem_req.we) |=> pslverr;
  endproperty
  a_add_dest: assert property (p_add_dest)
    else $error("indexed add read or destination wrong");
  a_bset: assert property (p_bset)
    else $error("bit set wrote the wrong byte");
  a_fill: assert property (p_fill)
    else $error("fill did not write all ones");
  a_index: assert property (p_index)
    else $error("indexed address is not pointer plus offset");
  a_literal: assert property (p_literal)
    else $error("literal address wrong");
  a_bad: assert property (p_bad)
    else $error("unknown opcode touched memory");
  a_ro_refused: assert property (p_ro_refused)
    else $error("write to read-only register not refused");
  a_ready: assert property (p_ready)
    else $error("access cycle without ready");
  a_busy_refused: assert property (p_busy_refused)
    else $error("write during an operation not refused");
endmodule // idx_op_decode_monitor

bind idx_op_decode idx_op_decode_monitor #(
  .ACCESS_SFR_BASE(ACCESS_SFR_BASE)
) mon_u (
  .mclk(mclk), .rstn(rstn), .paddr(paddr), .psel(psel),
  .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .mem_req(mem_req),
  .mem_rdata(mem_rdata)
);
`default_nettype wire

// >>> bench/idx_op_decode_tb_top.sv
// Self-checking bench for the indexed operation decoder over APB.
// Assumes the bench itself plays the byte data memory behind mem_req.
`timescale 1ns/1ps
`default_nettype none
module idx_op_decode_tb_top
  import idx_op_pkg::*;
;
  localparam logic [31:0] Z32 = 32'h0000_0000;
  logic        mclk = 1'b0;
  logic        rstn = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] pwdata = Z32;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  mem_req_t    mem_req;
  logic [7:0]  mem_rdata;
  logic [7:0]  mem_q [4096];
  logic [31:0] rd;
  logic        err;
  logic [7:0]  exp8;
  int          n_errors = 0;
  int          total_checks = 0;

  always #50 mclk = ~mclk;

  // Byte memory; an idle data line shows the inverse so stale reads stand out
  assign mem_rdata = mem_req.re ? mem_q[mem_req.addr] : ~mem_q[mem_req.addr];
  always @(posedge mclk) begin
    if (mem_req.we) mem_q[mem_req.addr] <= mem_req.wdata;
  end

  idx_op_decode dut_u (
    .mclk(mclk), .rstn(rstn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .mem_req(mem_req),
    .mem_rdata(mem_rdata)
  );

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One APB transfer; the request is held until pready is seen high
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge mclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge mclk);
    penable <= 1'b1;
    // No wait limit of its own: only the watchdog ends a missing answer
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, Z32);
    chk(rd, exp);
  endtask

  task automatic mc(input logic [11:0] a, input logic [7:0] exp);
    chk({24'h00_0000, mem_q[a]}, {24'h00_0000, exp});
  endtask

  // Poll busy until idle; a stuck operation is ended by the watchdog
  task automatic idle();
    do begin
      apb(1'b0, 8'h14, Z32);
    end while (rd[8] !== 1'b0);
  endtask

  task automatic run(input logic [15:0] op);
    apb(1'b1, 8'h04, {16'h0000, op});
    idle();
  endtask

  task automatic results();
    if (n_errors == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge mclk);
    n_errors++;
    results();
  end

  initial begin
    repeat (16) @(posedge mclk);
    rstn <= 1'b1;
    rdc(8'h00, 32'h0000_0001);
    rdc(8'h14, Z32);
    mem_q[12'hA2C] = 8'h20;
    mem_q[12'hA0A] = 8'h55;
    mem_q[12'h01C] = 8'h00;
    apb(1'b1, 8'h08, 32'h0000_0A00);
    apb(1'b1, 8'h10, 32'h0000_0017);
    run(16'h242C);
    rdc(8'h10, 32'h0000_0037);
    rdc(8'h14, Z32);
    mc(12'hA2C, 8'h20);
    // Sum of two negatives wraps: carry, half carry and signed overflow
    mem_q[12'hA2C] = 8'h88;
    apb(1'b1, 8'h10, 32'h0000_0088);
    run(16'h262C);
    mc(12'hA2C, 8'h10);
    rdc(8'h10, 32'h0000_0088);
    rdc(8'h14, 32'h0000_000B);
    exp8 = 8'h55;
    for (logic [3:0] b = 4'h0; b < 4'h8; b++) begin
      run({4'h8, b[2:0], 9'h00A});
      exp8 = exp8 | (8'h01 << b);
      mc(12'hA0A, exp8);
    end
    rdc(8'h14, 32'h0000_000B);
    // Offset at the boundary, with the pointer wrapping past the top
    apb(1'b1, 8'h08, 32'h0000_0FF0);
    run(16'h685F);
    mc(12'h04F, 8'hFF);
    run(16'h6860);
    mc(12'hF60, 8'hFF);
    rdc(8'h14, 32'h0000_000B);
    apb(1'b1, 8'h00, Z32);
    run(16'h682C);
    mc(12'h02C, 8'hFF);
    mc(12'h01C, 8'h00);
    apb(1'b1, 8'h0C, 32'h0000_0003);
    run(16'h6944);
    mc(12'h344, 8'hFF);
    // A write while an add is running must be refused and leave no trace
    apb(1'b1, 8'h04, 32'h0000_242C);
    apb(1'b1, 8'h10, 32'h0000_0055);
    chk(32'(err), 32'h0000_0001);
    idle();
    rdc(8'h10, 32'h0000_0087);
    apb(1'b1, 8'h18, Z32);
    chk(32'(err), 32'h0000_0001);
    apb(1'b1, 8'h1C, Z32);
    chk(32'(err), 32'h0000_0001);
    run(16'hFFFF);
    rdc(8'h14, 32'h0000_0213);
    // Writing one to the sticky bad flag clears it and reloads the flags
    apb(1'b1, 8'h14, 32'h0000_0200);
    rdc(8'h14, Z32);
    results();
  end
endmodule // idx_op_decode_tb_top
`default_nettype wire
